// ---- hdl/ldw_defines.vh ----
/*
 Constants for the legacy display window decoder: register offsets,
 field positions, reset values and the decoded address ranges.
 Assumes inclusion by the decoder modules only.
*/
`ifndef LDW_DEFINES_VH
`define LDW_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define LDW_OFS_CTRL 12'h000
`define LDW_OFS_STAT 12'h004
`define LDW_OFS_CLASS 12'h008

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define LDW_MODE_LSB 0
`define LDW_MODE_MSB 1
`define LDW_SUBP_BIT 2
`define LDW_SUBS_BIT 3
`define LDW_MODE_OFF 2'h0
`define LDW_MODE_DOWN 2'h1
`define LDW_MODE_UP 2'h2
`define LDW_MODE_BAD 2'h3
`define LDW_CTRL_RST 4'h0
`define LDW_CLASS_RST 24'h000000

// ----------------------------------------
// Decoded ranges
// ----------------------------------------
`define LDW_MEM_LO 32'h000A0000
`define LDW_MEM_HI 32'h000BFFFF
`define LDW_IO_A_LO 10'h3B0
`define LDW_IO_A_HI 10'h3BB
`define LDW_IO_B_LO 10'h3C0
`define LDW_IO_B_HI 10'h3DF

`endif

// ---- hdl/ldw_match.v ----
/*
 Address match for the legacy display window.
 Assumes a combinational address and space flag from a target decoder.
*/
`timescale 1ns/1ps
`include "ldw_defines.vh"

module ldw_match (
	input wire [31:0] addr,
	input wire is_io,
	output wire hit
);

	// ----------------------------------------
	// Range compare, no translation
	// ----------------------------------------
	wire mem_hit;
	wire io_hit;
	assign mem_hit = (addr >= `LDW_MEM_LO) && (addr <= `LDW_MEM_HI);
	// I/O compare looks at the low ten bits only
	assign io_hit = ((addr[9:0] >= `LDW_IO_A_LO) && (addr[9:0] <= `LDW_IO_A_HI))
		|| ((addr[9:0] >= `LDW_IO_B_LO) && (addr[9:0] <= `LDW_IO_B_HI));
	assign hit = is_io ? io_hit : mem_hit;

endmodule

// ---- hdl/ldw_decode.v ----
/*
 Legacy display window decoder with an APB register slave.
 Assumes PCI address phases are presented as one-cycle strobes with
 address and space flags, synchronous to pclk, and that the bridge core
 uses the claim and forward outputs to steer transactions.
*/
// The register addresses and register access over APB were left to the implementer.
// Operation
// - Mode 01b: claim primary display cycles and forward them downstream.
// - Memory window is 000A0000h to 000BFFFFh inclusive.
// - I/O ranges 3B0h-3BBh and 3C0h-3DFh, low ten bits, untranslated.
// - Mode 10b: claim secondary display cycles and forward them upstream.
// - Upstream uses same ranges, no translation.
// - Mode loadable by ROM preload, primary or secondary config write.
// - No palette-snooping mode exists.
// - Subtractive I/O forwarded untranslated; unclaimed secondary cycle returns upstream.
`timescale 1ns/1ps
`include "ldw_defines.vh"

module ldw_decode (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire rom_load,
	input wire [1:0] rom_mode,
	input wire [23:0] rom_class,
	input wire pri_cfg_wr,
	input wire sec_cfg_wr,
	input wire [1:0] cfg_mode,
	input wire pri_addr_vld,
	input wire [31:0] pri_addr,
	input wire pri_is_io,
	input wire pri_sub_io,
	input wire sec_addr_vld,
	input wire [31:0] sec_addr,
	input wire sec_is_io,
	input wire sec_no_resp,
	output reg pri_claim_ff,
	output reg sec_claim_ff,
	output reg fwd_down_ff,
	output reg fwd_up_ff,
	output reg [31:0] fwd_addr_ff,
	output wire [23:0] class_code
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [3:0] ctrl_ff;
	reg [23:0] class_ff;
	reg illegal_ff;
	reg [3:0] nxt_ctrl;
	wire apb_wr;
	wire hit_ctrl;
	wire hit_stat;
	wire hit_class;
	wire [1:0] mode;
	wire pri_hit;
	wire sec_hit;

	assign pready = 1'b1;
	assign hit_ctrl = (paddr == `LDW_OFS_CTRL);
	assign hit_stat = (paddr == `LDW_OFS_STAT);
	assign hit_class = (paddr == `LDW_OFS_CLASS);
	assign pslverr = psel && penable && !(hit_ctrl || hit_stat || hit_class);
	assign apb_wr = psel && penable && pwrite;
	assign mode = ctrl_ff[`LDW_MODE_MSB:`LDW_MODE_LSB];
	assign class_code = class_ff;

	// ROM and config writes load the mode field only; APB writes all four bits; no snoop bit is implemented
	always @* begin
		nxt_ctrl = ctrl_ff;
		if (rom_load) begin
			nxt_ctrl[`LDW_MODE_MSB:`LDW_MODE_LSB] = rom_mode;
		end else if (pri_cfg_wr || sec_cfg_wr) begin
			nxt_ctrl[`LDW_MODE_MSB:`LDW_MODE_LSB] = cfg_mode;
		end else if (apb_wr && hit_ctrl) begin
			nxt_ctrl = pwdata[3:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `LDW_CTRL_RST;
			class_ff <= `LDW_CLASS_RST;
			illegal_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (rom_load) begin
				class_ff <= rom_class;
			end else if (apb_wr && hit_class) begin
				class_ff <= pwdata[23:0];
			end
			illegal_ff <= (nxt_ctrl[`LDW_MODE_MSB:`LDW_MODE_LSB] == `LDW_MODE_BAD);
		end
	end

	always @* begin
		prdata = 32'h00000000;
		if (hit_ctrl) begin
			prdata[3:0] = ctrl_ff;
		end else if (hit_stat) begin
			prdata[3:0] = {fwd_up_ff, fwd_down_ff, illegal_ff, sec_claim_ff};
		end else if (hit_class) begin
			prdata[23:0] = class_ff;
		end
	end

	// ----------------------------------------
	// Decode and claim
	// ----------------------------------------
	ldw_match u_pri (
		.addr(pri_addr),
		.is_io(pri_is_io),
		.hit(pri_hit)
	);

	ldw_match u_sec (
		.addr(sec_addr),
		.is_io(sec_is_io),
		.hit(sec_hit)
	);

	// Mode 11b makes no range-decode claim here, only enabled subtractive claims; its outcome is left to software
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pri_claim_ff <= 1'b0;
			sec_claim_ff <= 1'b0;
			fwd_down_ff <= 1'b0;
			fwd_up_ff <= 1'b0;
			fwd_addr_ff <= 32'h00000000;
		end else begin
			pri_claim_ff <= 1'b0;
			sec_claim_ff <= 1'b0;
			fwd_down_ff <= 1'b0;
			fwd_up_ff <= 1'b0;
			if (pri_addr_vld && ((mode == `LDW_MODE_DOWN && pri_hit)
				|| (pri_is_io && ctrl_ff[`LDW_SUBP_BIT] && pri_sub_io))) begin
				pri_claim_ff <= 1'b1;
				fwd_down_ff <= 1'b1;
				fwd_addr_ff <= pri_addr;
			end else if (sec_addr_vld && ((mode == `LDW_MODE_UP && sec_hit)
				|| (sec_is_io && ctrl_ff[`LDW_SUBS_BIT] && sec_no_resp))) begin
				sec_claim_ff <= 1'b1;
				fwd_up_ff <= 1'b1;
				fwd_addr_ff <= sec_addr;
			end
		end
	end

endmodule

// ---- verification/ldw_monitor.sv ----
/* Checker for the decoder's claim, forward and pass-through outputs.
 Assumes it is bound to ldw_decode and sees its ports by name. */
`timescale 1ns/1ps
module ldw_monitor (
	input wire pclk, input wire presetn,
	input wire pri_addr_vld, input wire [31:0] pri_addr, input wire pri_is_io,
	input wire pri_sub_io, input wire sec_addr_vld, input wire [31:0] sec_addr,
	input wire pri_claim_ff, input wire sec_claim_ff, input wire fwd_down_ff,
	input wire fwd_up_ff, input wire [31:0] fwd_addr_ff
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_mem_miss;
		pri_addr_vld && !pri_is_io && (pri_addr < 32'h000A0000 || pri_addr > 32'h000BFFFF);
	endsequence
	sequence s_io_miss;
		pri_addr_vld && pri_is_io && !pri_sub_io &&
			!(pri_addr[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]});
	endsequence
	a_pri_cause: assert property (pri_claim_ff |-> $past(pri_addr_vld))
		else $error("primary claim without strobe");
	a_sec_cause: assert property (sec_claim_ff |-> $past(sec_addr_vld))
		else $error("secondary claim without strobe");
	a_down_pair: assert property (fwd_down_ff == pri_claim_ff)
		else $error("downstream forward apart from claim");
	a_up_pair: assert property (fwd_up_ff == sec_claim_ff)
		else $error("upstream forward apart from claim");
	a_down_addr: assert property (pri_claim_ff |-> fwd_addr_ff == $past(pri_addr))
		else $error("downstream address altered");
	a_up_addr: assert property (sec_claim_ff |-> fwd_addr_ff == $past(sec_addr))
		else $error("upstream address altered");
	a_mem_miss: assert property (s_mem_miss |=> !pri_claim_ff)
		else $error("memory claim outside window");
	a_io_miss: assert property (s_io_miss |=> !pri_claim_ff)
		else $error("io claim outside ranges");
endmodule
bind ldw_decode ldw_monitor u_mon (.*);

// ---- verification/ldw_agent.sv ----
/* Far-side bus agent: one address phase per request.
 Assumes requests change just after a rising edge. */
`timescale 1ns/1ps
module ldw_agent (
	input wire pclk, input wire req, input wire [31:0] req_addr, input wire req_io,
	output logic vld = 1'b0, output logic [31:0] addr = 32'h0, output logic is_io = 1'b0
);
	// Outside an address phase the released lines invert each cycle, so they show the last value again every second cycle
	always @(posedge pclk) begin
		vld <= req;
		addr <= req ? req_addr : ~addr;
		is_io <= req ? req_io : ~is_io;
	end
endmodule

// ---- verification/testbench.sv ----
/* Self-checking bench for ldw_decode over APB and both address buses.
 Assumes the agent model and the bound monitor. */
`timescale 1ns/1ps
module testbench;
	logic pclk=0, presetn=0, psel=0, penable=0, pwrite=0, rom_load=0, pri_cfg_wr=0, sec_cfg_wr=0;
	logic pri_sub_io=0, sec_no_resp=0, pq=0, sq=0, io=0, er;
	logic [11:0] paddr=12'h0;
	logic [31:0] pwdata=32'h0, a=32'h0, rd;
	logic [1:0] rom_mode=2'h1, cfg_mode=2'h0;
	logic [23:0] rom_class=24'h030000;
	logic [31:0] ta [10] = '{32'h000A0000, 32'h000BFFFF, 32'h0009FFFF, 32'h000C0000,
		32'h3B0, 32'h3BB, 32'h3AF, 32'h3DF, 32'h3E0, 32'h7C0};
	logic [9:0] tio=10'h3F0, te=10'h2B3;
	wire [31:0] prdata, pri_addr, sec_addr, fwd_addr_ff;
	wire [23:0] class_code;
	wire pready, pslverr, pri_addr_vld, pri_is_io, sec_addr_vld, sec_is_io;
	wire pri_claim_ff, sec_claim_ff, fwd_down_ff, fwd_up_ff;
	int mismatches=0, samples_checked=0, cyc=0;
	initial forever #10 pclk = ~pclk;
	ldw_agent pri (.pclk, .req(pq), .req_addr(a), .req_io(io), .vld(pri_addr_vld),
		.addr(pri_addr), .is_io(pri_is_io));
	ldw_agent sec (.pclk, .req(sq), .req_addr(a), .req_io(io), .vld(sec_addr_vld),
		.addr(sec_addr), .is_io(sec_is_io));
	ldw_decode uut (.*);
	task close_out;
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk); psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d;
		@(posedge pclk); penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata; er = pslverr; psel <= 0; penable <= 0;
	endtask
	task probe(input logic s, input logic [31:0] ad, input logic i, input logic e);
		@(posedge pclk); a <= ad; io <= i; pq <= !s; sq <= s;
		@(posedge pclk); pq <= 0; sq <= 0;
		@(posedge pclk); #1 chk(s ? {sec_claim_ff, fwd_up_ff} : {pri_claim_ff, fwd_down_ff}, {2{e}});
		if (e) chk(fwd_addr_ff, ad);
	endtask
	task sweep(input logic s, input logic on);
		for (int i = 0; i < 10; i++) probe(s, ta[i], tio[i], on & te[i]);
	endtask
	always @(posedge pclk) if (++cyc == 3000) begin mismatches++; close_out; end
	initial begin
		repeat (8) @(posedge pclk); presetn <= 1;
		apb(0, 12'h000, 32'h0); chk(rd, 32'h0);
		apb(0, 12'h004, 32'h0); chk(rd, 32'h0);
		sweep(0, 0);
		apb(1, 12'h000, 32'h1); sweep(0, 1);
		sweep(1, 0);
		@(posedge pclk) cfg_mode <= 2'h2; pri_cfg_wr <= 1;
		@(posedge pclk) pri_cfg_wr <= 0; sweep(1, 1);
		sweep(0, 0);
		@(posedge pclk) cfg_mode <= 2'h0; sec_cfg_wr <= 1;
		@(posedge pclk) sec_cfg_wr <= 0; sweep(1, 0);
		@(posedge pclk) rom_load <= 1; @(posedge pclk) rom_load <= 0;
		apb(0, 12'h008, 32'h0); chk(rd, 32'h030000);
		chk(class_code, 32'h030000);
		apb(0, 12'h000, 32'h0); chk(rd, 32'h1);
		apb(1, 12'h000, 32'hFFFFFFF4);
		apb(0, 12'h000, 32'h0); chk(rd, 32'h4);
		pri_sub_io <= 1; probe(0, 32'h100, 1, 1);
		apb(1, 12'h000, 32'h8); sec_no_resp <= 1; probe(1, 32'h104, 1, 1);
		apb(0, 12'h0FC, 32'h0); chk(er, 32'h1);
		@(posedge pclk) presetn <= 0;
		@(posedge pclk) presetn <= 1;
		apb(0, 12'h000, 32'h0); chk(rd, 32'h0);
		chk(class_code, 32'h0);
		close_out;
	end
endmodule
